// ### ofcd_dev.sv
// flash device end: samples the link, decodes opcodes and streams read data
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module ofcd_dev #(
  parameter int ADDR_W = 25,
  parameter bit RWW = 1'b1
) (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // link
  ofcd_link_if.dev link,
  // configuration and status
  input wire logic octal_mode,
  input wire logic addr4_mode,
  input wire logic wr_reg_busy,
  input wire logic pe_busy,
  input wire logic [1:0] pe_bank,
  // array and register read
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic reg_sel,
  input wire logic [7:0] reg_rdata,
  // events
  output logic active,
  output logic [3:0] ctrl_stb
);
  import ofcd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 3 only feeds edge detection
  // dq goes through the same two stages as sck so each bit lines up with its edge
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic [7:0] dq_s1_q, dq_s2_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
      {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
      dq_s1_q <= 8'hFF;
      dq_s2_q <= 8'hFF;
    end else begin
      {sck_s1_q, sck_s2_q, sck_s3_q} <= {link.sck, sck_s1_q, sck_s2_q};
      {cs_s1_q, cs_s2_q, cs_s3_q} <= {link.cs_n, cs_s1_q, cs_s2_q};
      dq_s1_q <= link.dq;
      dq_s2_q <= dq_s1_q;
    end
  end

  wire sck_rise = sck_s2_q & ~sck_s3_q;
  wire sck_fall = ~sck_s2_q & sck_s3_q;
  wire cs_fall = ~cs_s2_q & cs_s3_q;
  wire cs_rise = cs_s2_q & ~cs_s3_q;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  ofcd_phase_t state_q;
  ofcd_cmd_t cmd_q;
  logic [31:0] sr_q;
  logic [5:0] cnt_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic reg_sel_q;
  logic active_q;
  logic [3:0] ctrl_stb_q;
  logic [7:0] dq_o_q;
  logic [7:0] dq_oe_q;

  // extended frames gather the opcode one bit at a time on dq[0]
  wire [7:0] cmd_in = octal_mode ? dq_s2_q : {sr_q[6:0], dq_s2_q[0]};
  ofcd_cmd_t dec;
  assign dec = ofcd_decode(cmd_in, octal_mode, addr4_mode);
  // array refused while a register write runs, or while a program/erase runs
  // unless the part has the bank option and the read is a fast one
  wire array_blk = (dec.kind == KIND_ARRAY) &&
                   (wr_reg_busy || (pe_busy && !(RWW && dec.fast)));
  wire cmd_bad = !dec.valid || array_blk;
  ofcd_phase_t nxt_c;
  assign nxt_c = ofcd_after(dec, PH_CMD);
  wire [5:0] len_c = ofcd_len(dec, nxt_c);
  wire [3:0] stb_c = {cmd_in == OP_WR_DIS, cmd_in == OP_WR_EN,
                      cmd_in == OP_RST_MEM, cmd_in == OP_RST_EN};

  wire [31:0] addr_in = cmd_q.addr_oct ? {sr_q[23:0], dq_s2_q} : {sr_q[30:0], dq_s2_q[0]};
  // under the bank option a fast read is off limits only in the busy bank
  wire bank_blk = pe_busy && (addr_in[ADDR_W-1 -: 2] == pe_bank);
  ofcd_phase_t nxt_a;
  assign nxt_a = ofcd_after(cmd_q, PH_ADDR);
  wire [5:0] len_a = ofcd_len(cmd_q, nxt_a);
  wire [5:0] len_d = ofcd_len(cmd_q, PH_DATA);
  // counters load a phase's length and the phase ends on a count of one
  wire last = (cnt_q == 6'h01);

  //////////////////////////////////////////////////////////////////////////////
  // read data: a register byte is fetched afresh each byte, so it repeats
  wire [7:0] src = (cmd_q.kind == KIND_ARRAY) ? mem_rdata : reg_rdata;
  wire [2:0] bit_ix = cnt_q[2:0] - 3'h1;
  wire [7:0] out_d = cmd_q.data_oct ? src : {6'h00, src[bit_ix], 1'b0};
  wire [7:0] oe_d = cmd_q.data_oct ? 8'hFF : 8'h02;

  //////////////////////////////////////////////////////////////////////////////
  // frame sequencer: select fall opens a frame, select rise closes it from any
  // phase; a refused opcode or a busy bank parks the frame in idle, so the rest
  // of its clocks are ignored until the next select fall
  // octal frames are single rate, one byte per clock rise; a double-rate host
  // would need both clock edges and a data strobe, which are not provided
  always_ff @(posedge clk_sys) begin
    ctrl_stb_q <= 4'h0;
    if (srst || cs_rise) begin
      state_q <= PH_IDLE;
      active_q <= 1'b0;
      dq_oe_q <= 8'h00;
      dq_o_q <= 8'h00;
      if (srst) begin
        cmd_q <= '0;
        sr_q <= 32'h0;
        cnt_q <= 6'h00;
        mem_addr_q <= '0;
        reg_sel_q <= 1'b0;
      end
    end else if (cs_fall) begin
      state_q <= PH_CMD;
      active_q <= 1'b0;
      sr_q <= 32'h0;
      cnt_q <= octal_mode ? CMD_CLK_OCT : CMD_CLK_EXT;
    end else begin
      case (state_q)
        PH_CMD: if (sck_rise) begin
          sr_q <= {24'h0, cmd_in};
          cnt_q <= cnt_q - 6'h01;
          if (last) begin
            // address shifts in from zero, so a three-byte address leaves the
            // top bits clear instead of holding the opcode's low bit
            sr_q <= 32'h0;
            cmd_q <= dec;
            reg_sel_q <= (cmd_in == OP_RD_FLAG);
            cnt_q <= len_c;
            if (cmd_bad) begin
              state_q <= PH_IDLE;
            end else begin
              state_q <= nxt_c;
              active_q <= 1'b1;
              if (dec.kind == KIND_CTRL) ctrl_stb_q <= stb_c;
            end
          end
        end
        PH_ADDR: if (sck_rise) begin
          sr_q <= addr_in;
          cnt_q <= cnt_q - 6'h01;
          if (last) begin
            mem_addr_q <= addr_in[ADDR_W-1:0];
            cnt_q <= len_a;
            if (bank_blk) begin
              state_q <= PH_IDLE;
              active_q <= 1'b0;
            end else begin
              state_q <= nxt_a;
            end
          end
        end
        PH_DUMMY: if (sck_rise) begin
          cnt_q <= cnt_q - 6'h01;
          if (last) begin
            state_q <= PH_DATA;
            cnt_q <= len_d;
          end
        end
        // data moves about three clocks after the host's fall; the half period
        // must stay well above that or the host samples a bit in motion
        PH_DATA: if (sck_fall) begin
          dq_o_q <= out_d;
          dq_oe_q <= oe_d;
          cnt_q <= cnt_q - 6'h01;
          if (last) begin
            cnt_q <= len_d;
            if (cmd_q.kind == KIND_ARRAY) mem_addr_q <= mem_addr_q + 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign link.dev_dq_o = dq_o_q;
  assign link.dev_dq_oe = dq_oe_q;
  assign mem_addr = mem_addr_q;
  assign reg_sel = reg_sel_q;
  assign active = active_q;
  assign ctrl_stb = ctrl_stb_q;

endmodule // ofcd_dev

// ### ofcd_host.sv
// flash controller end: makes the serial clock and runs one command per start
`timescale 1ns/100ps
module ofcd_host #(
  parameter int SCK_HALF = ofcd_pkg::SCK_HALF_CYC,
  parameter int LEN_W = 16
) (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // link
  ofcd_link_if.host link,
  // command request
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [31:0] addr,
  input wire logic [LEN_W-1:0] rd_len,
  input wire logic octal_mode,
  input wire logic addr4_mode,
  // status and read data
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic rvalid
);
  import ofcd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] dq_s1_q, dq_s2_q;
  ofcd_phase_t state_q;
  ofcd_cmd_t cmd_q;
  logic [15:0] div_q;
  logic sck_q, cs_n_q, done_q, rvalid_q, tx8_q;
  logic [31:0] tx_q;
  logic [5:0] cnt_q;
  logic [LEN_W-1:0] bytes_q;
  logic [7:0] rx_q, rdata_q, dq_o_q, dq_oe_q;

  always_ff @(posedge clk_sys) begin
    dq_s1_q <= link.dq;
    dq_s2_q <= dq_s1_q;
  end

  wire run = (state_q != PH_IDLE);
  wire tick = run && (div_q == 16'(SCK_HALF - 1));

  always_ff @(posedge clk_sys) begin
    if (srst || !run || tick) div_q <= 16'h0000;
    else div_q <= div_q + 16'h0001;
  end

  // start and phase entry values
  ofcd_cmd_t dec;
  assign dec = ofcd_decode(opcode, octal_mode, addr4_mode);
  ofcd_phase_t nxt_raw, nxt;
  assign nxt_raw = (state_q == PH_DATA) ? PH_DATA : ofcd_after(cmd_q, state_q);
  assign nxt = (nxt_raw == PH_DATA && bytes_q == '0) ? PH_HOLD : nxt_raw;
  wire [31:0] ld = (cmd_q.addr_bytes == ADDR_B4) ? addr : {addr[23:0], 8'h00};
  wire [7:0] tx_out = tx8_q ? tx_q[31:24] : {7'h00, tx_q[31]};
  wire [31:0] tx_sh = tx8_q ? {tx_q[23:0], 8'h00} : {tx_q[30:0], 1'b0};
  wire [7:0] ld_out = cmd_q.addr_oct ? ld[31:24] : {7'h00, ld[31]};
  wire [31:0] ld_sh = cmd_q.addr_oct ? {ld[23:0], 8'h00} : {ld[30:0], 1'b0};
  wire [7:0] rx_d = cmd_q.data_oct ? dq_s2_q : {rx_q[6:0], dq_s2_q[1]};

  always_ff @(posedge clk_sys) begin
    done_q <= 1'b0;
    rvalid_q <= 1'b0;
    if (srst) begin
      state_q <= PH_IDLE;
      cmd_q <= '0;
      {sck_q, tx8_q} <= 2'b00;
      cs_n_q <= 1'b1;
      tx_q <= 32'h0;
      cnt_q <= 6'h00;
      bytes_q <= '0;
      {rx_q, rdata_q, dq_o_q, dq_oe_q} <= 32'h0;
    end else if (state_q == PH_IDLE) begin
      if (start) begin
        state_q <= PH_CMD;
        cmd_q <= dec;
        cs_n_q <= 1'b0;
        tx8_q <= octal_mode;
        tx_q <= octal_mode ? 32'h0 : {opcode[6:0], 25'h0};
        dq_o_q <= octal_mode ? opcode : {7'h00, opcode[7]};
        dq_oe_q <= octal_mode ? 8'hFF : 8'h01;
        cnt_q <= octal_mode ? CMD_CLK_OCT : CMD_CLK_EXT;
        bytes_q <= rd_len;
      end
    end else if (tick && state_q == PH_HOLD) begin
      // one half period with clock low before select rises
      state_q <= PH_IDLE;
      cs_n_q <= 1'b1;
      dq_oe_q <= 8'h00;
      done_q <= 1'b1;
    end else if (tick && !sck_q) begin
      sck_q <= 1'b1;
      cnt_q <= cnt_q - 6'h01;
      if (state_q == PH_DATA) begin
        rx_q <= rx_d;
        if (cnt_q == 6'h01) begin
          rdata_q <= rx_d;
          rvalid_q <= 1'b1;
          bytes_q <= bytes_q - 1'b1;
        end
      end
    end else if (tick) begin
      sck_q <= 1'b0;
      if (cnt_q != 6'h00) begin
        dq_o_q <= tx_out;
        tx_q <= tx_sh;
      end else begin
        state_q <= nxt;
        cnt_q <= ofcd_len(cmd_q, nxt);
        dq_oe_q <= 8'h00;
        if (nxt == PH_ADDR) begin
          tx8_q <= cmd_q.addr_oct;
          dq_o_q <= ld_out;
          dq_oe_q <= cmd_q.addr_oct ? 8'hFF : 8'h01;
          tx_q <= ld_sh;
        end
      end
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.host_dq_o = dq_o_q;
  assign link.host_dq_oe = dq_oe_q;
  assign busy = run;
  assign done = done_q;
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

endmodule // ofcd_host

// ### ofcd_link_if.sv
// link wires between the flash controller end and the flash device end
`timescale 1ns/100ps
interface ofcd_link_if;
  logic sck;
  logic cs_n;
  logic [7:0] host_dq_o;
  logic [7:0] host_dq_oe;
  logic [7:0] dev_dq_o;
  logic [7:0] dev_dq_oe;
  logic [7:0] dq;

  // resolved bus level; undriven lines float high through a pull-up
  assign dq = (host_dq_oe & host_dq_o) | (dev_dq_oe & dev_dq_o) | ~(host_dq_oe | dev_dq_oe);

  modport host (output sck, output cs_n, output host_dq_o, output host_dq_oe, input dq);
  modport dev (input sck, input cs_n, output dev_dq_o, output dev_dq_oe, input dq);
endinterface

// ### ofcd_link_props.sv
// link checker for the octal flash command link
`timescale 1ns/100ps
module ofcd_link_props (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [7:0] host_dq_oe,
  input wire logic [7:0] dev_dq_o,
  input wire logic [7:0] dev_dq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////////
  chk_one_driver: assert property ((host_dq_oe & dev_dq_oe) == 8'h00)
    else $error("both ends drive dq");
  chk_oe_width: assert property (dev_dq_oe inside {8'h00, 8'h02, 8'hFF})
    else $error("device drives an odd set of lines");
  chk_cmd_silent: assert property ($fell(cs_n) |-> (dev_dq_oe == 8'h00)[*8])
    else $error("device drives during command");
  chk_release_bound: assert property ($rose(cs_n) |-> ##[1:5] (dev_dq_oe == 8'h00))
    else $error("device keeps driving after deselect");
  chk_idle_quiet: assert property (cs_n[*6] |-> dev_dq_oe == 8'h00)
    else $error("device drives while deselected");
  // data may only move while the clock is low, so the host sees it settled
  chk_drive_low: assert property ($changed(dev_dq_o) && dev_dq_oe != 8'h00 |-> !sck)
    else $error("device data changes while clock high");
  chk_sck_high: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
    else $error("clock high phase not eight cycles");
  chk_sck_low: assert property ($fell(sck) |-> !sck[*8])
    else $error("clock low phase too short");
  chk_cs_idle_clk: assert property (cs_n |-> !sck)
    else $error("clock runs while deselected");
  cover property (dev_dq_oe == 8'hFF);
  cover property (dev_dq_oe == 8'h02);
  cover property ($rose(cs_n) && host_dq_oe == 8'h00);
endmodule // ofcd_link_props

// ### ofcd_pkg.sv
// shared opcodes, command decode and phase sequencing for the octal flash command link
package ofcd_pkg;

  // opcodes
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST_MEM = 8'h99;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_FRD = 8'h0B;
  localparam logic [7:0] OP_ORD = 8'h8B;
  localparam logic [7:0] OP_OIORD = 8'hCB;
  localparam logic [7:0] OP_DORD = 8'h9D;
  localparam logic [7:0] OP_DOIORD = 8'hFD;
  localparam logic [7:0] OP_RD4 = 8'h13;
  localparam logic [7:0] OP_FRD4 = 8'h0C;
  localparam logic [7:0] OP_ORD4 = 8'h7C;
  localparam logic [7:0] OP_OIORD4 = 8'hCC;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_RD_FLAG = 8'h70;

  // cycle counts
  localparam logic [4:0] DUMMY_EXT = 5'h08;
  localparam logic [4:0] DUMMY_OCT = 5'h10;
  localparam logic [4:0] DUMMY_REG_OCT = 5'h08;
  localparam logic [5:0] CMD_CLK_EXT = 6'h08;
  localparam logic [5:0] CMD_CLK_OCT = 6'h01;
  localparam logic [2:0] ADDR_B3 = 3'h3;
  localparam logic [2:0] ADDR_B4 = 3'h4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // control strobe positions
  localparam int STB_RST_EN = 0;
  localparam int STB_RST_MEM = 1;
  localparam int STB_WR_EN = 2;
  localparam int STB_WR_DIS = 3;

  typedef enum logic [1:0] {KIND_NONE, KIND_CTRL, KIND_REG, KIND_ARRAY} ofcd_kind_t;
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_HOLD} ofcd_phase_t;

  typedef struct packed {
    logic valid;
    ofcd_kind_t kind;
    logic fast;
    logic addr_oct;
    logic [2:0] addr_bytes;
    logic data_oct;
    logic [4:0] dummy;
  } ofcd_cmd_t;

  function automatic ofcd_cmd_t ofcd_decode(input logic [7:0] op, input logic octal,
                                            input logic addr4);
    ofcd_cmd_t c;
    logic [2:0] ab;
    logic [4:0] fd;
    c = '0;
    ab = addr4 ? ADDR_B4 : ADDR_B3;
    fd = octal ? DUMMY_OCT : DUMMY_EXT;
    c.kind = KIND_ARRAY;
    c.valid = 1'b1;
    c.fast = 1'b1;
    case (op)
      OP_RST_EN, OP_RST_MEM, OP_WR_EN, OP_WR_DIS: begin
        c.kind = KIND_CTRL;
        c.fast = 1'b0;
      end
      OP_RD, OP_RD4: begin
        c.valid = !octal;
        c.fast = 1'b0;
        c.addr_bytes = (op == OP_RD4) ? ADDR_B4 : ab;
      end
      OP_FRD, OP_FRD4: begin
        c.addr_bytes = (op == OP_FRD4) ? ADDR_B4 : ab;
        c.dummy = fd;
      end
      OP_ORD, OP_DORD, OP_ORD4: begin
        c.addr_bytes = (op == OP_ORD4) ? ADDR_B4 : ab;
        c.data_oct = 1'b1;
        c.dummy = fd;
      end
      OP_OIORD, OP_DOIORD, OP_OIORD4: begin
        c.addr_bytes = (op == OP_OIORD) ? ab : ADDR_B4;
        c.addr_oct = 1'b1;
        c.data_oct = 1'b1;
        c.dummy = DUMMY_OCT;
      end
      OP_RD_STAT, OP_RD_FLAG: begin
        c.kind = KIND_REG;
        c.fast = 1'b0;
        c.dummy = octal ? DUMMY_REG_OCT : 5'h00;
      end
      default: begin
        c.valid = 1'b0;
        c.kind = KIND_NONE;
        c.fast = 1'b0;
      end
    endcase
    if (octal) begin
      c.addr_oct = 1'b1;
      c.data_oct = 1'b1;
    end
    return c;
  endfunction

  // phase that follows ph; PH_HOLD means the command carries nothing more
  function automatic ofcd_phase_t ofcd_after(input ofcd_cmd_t c, input ofcd_phase_t ph);
    ofcd_phase_t n;
    n = PH_HOLD;
    if (!c.valid) n = PH_HOLD;
    else if (ph == PH_CMD && c.addr_bytes != 3'h0) n = PH_ADDR;
    else if (ph != PH_DUMMY && c.dummy != 5'h00) n = PH_DUMMY;
    else if (c.kind == KIND_REG || c.kind == KIND_ARRAY) n = PH_DATA;
    return n;
  endfunction

  // sck cycles of a phase (per byte for data)
  function automatic logic [5:0] ofcd_len(input ofcd_cmd_t c, input ofcd_phase_t ph);
    logic [5:0] l;
    l = 6'h00;
    if (ph == PH_ADDR) l = c.addr_oct ? {3'h0, c.addr_bytes} : {c.addr_bytes, 3'h0};
    else if (ph == PH_DUMMY) l = {1'b0, c.dummy};
    else if (ph == PH_DATA) l = c.data_oct ? 6'h01 : 6'h08;
    return l;
  endfunction

endpackage

// ### tb_top.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/100ps
module tb_top;
  import ofcd_pkg::*;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic start = 1'h0;
  logic [7:0] opcode = 8'h00;
  logic [31:0] addr = 32'h0;
  logic [15:0] rd_len = 16'h0;
  logic octal_mode = 1'h0;
  logic addr4_mode = 1'h0;
  logic wr_reg_busy = 1'h0;
  logic pe_busy = 1'h0;
  logic [1:0] pe_bank = 2'h0;
  logic busy, done, rvalid, active, reg_sel, act_seen;
  logic [7:0] rdata, mem_rdata, reg_rdata;
  logic [24:0] mem_addr;
  logic [3:0] ctrl_stb, stb_seen;
  logic [7:0] ctl[4] = '{8'h66, 8'h99, 8'h06, 8'h04};
  logic [7:0] rdo[12] = '{8'h03, 8'h0B, 8'h8B, 8'hCB, 8'h9D, 8'hFD, 8'h13, 8'h0C, 8'h7C,
                          8'hCC, 8'h05, 8'h70};
  logic [7:0] rx[$];
  int errors = 0;
  int n_checks = 0;
  int rises, lat;
  ofcd_link_if link ();
  ofcd_host ofcd_host_i (.clk_sys(clk_sys), .srst(srst), .link(link.host), .start(start),
    .opcode(opcode), .addr(addr), .rd_len(rd_len), .octal_mode(octal_mode),
    .addr4_mode(addr4_mode), .busy(busy), .done(done), .rdata(rdata), .rvalid(rvalid));
  ofcd_dev ofcd_dev_i (.clk_sys(clk_sys), .srst(srst), .link(link.dev),
    .octal_mode(octal_mode), .addr4_mode(addr4_mode), .wr_reg_busy(wr_reg_busy),
    .pe_busy(pe_busy), .pe_bank(pe_bank), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .reg_sel(reg_sel), .reg_rdata(reg_rdata), .active(active), .ctrl_stb(ctrl_stb));
  ofcd_link_props ofcd_link_props_i (.clk_sys(clk_sys), .srst(srst), .sck(link.sck),
    .cs_n(link.cs_n), .host_dq_oe(link.host_dq_oe), .dev_dq_o(link.dev_dq_o),
    .dev_dq_oe(link.dev_dq_oe));
  // array byte depends on its address so a skipped or repeated address shows
  assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
  assign reg_rdata = reg_sel ? 8'hC3 : 8'h3C;
  initial forever #5 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge link.sck) rises++;
  always @(posedge clk_sys) begin
    if (lat < 0 && !link.cs_n && link.dev_dq_oe != 8'h00) lat = rises;
    if (rvalid === 1'h1) rx.push_back(rdata);
    stb_seen = stb_seen | ctrl_stb;
    act_seen = act_seen | active;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // clock rises before the device first drives: command, address and dummy
  function automatic int exp_lat(input logic [7:0] op, input bit oct, input bit a4);
    int ab, d;
    ab = (op inside {8'hFD, 8'hCC, 8'h13, 8'h0C, 8'h7C} || a4) ? 4 : 3;
    d = oct ? 16 : 8;
    if (op inside {8'h05, 8'h70}) ab = 0;
    if (op inside {8'h05, 8'h70}) d = oct ? 8 : 0;
    if (op inside {8'h03, 8'h13}) d = 0;
    if (op inside {8'hCB, 8'hFD, 8'hCC}) d = 16;
    if (!oct && !(op inside {8'hCB, 8'hFD, 8'hCC})) ab = ab * 8;
    return (oct ? 1 : 8) + ab + d;
  endfunction
  task automatic run(input logic [7:0] op, input logic [31:0] a, input int len,
                     input bit oct, input bit a4);
    int i;
    @(negedge clk_sys);
    opcode = op;
    addr = a;
    rd_len = len[15:0];
    octal_mode = oct;
    addr4_mode = a4;
    rises = 0;
    lat = -1;
    rx.delete();
    stb_seen = 4'h0;
    act_seen = 1'h0;
    start = 1'h1;
    @(negedge clk_sys);
    start = 1'h0;
    chk("busy", 32'h1, {31'h0, busy});
    for (i = 0; i < 30000 && done !== 1'h1; i++) @(negedge clk_sys);
    chk("frame end", 32'h1, {31'h0, done});
    repeat (6) @(negedge clk_sys);
    chk("active after frame", 32'h0, {31'h0, active});
    chk("busy after frame", 32'h0, {31'h0, busy});
  endtask
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input bit oct, input bit a4,
                    input bit ok);
    logic [7:0] e;
    run(op, a, 2, oct, a4);
    chk("latency", ok ? exp_lat(op, oct, a4) : -1, lat);
    if (ok) begin
      chk("active seen", 32'h1, {31'h0, act_seen});
      chk("byte count", 32'h2, rx.size());
      foreach (rx[k]) begin
        e = (op == 8'h70) ? 8'hC3 : (op == 8'h05) ? 8'h3C : (a[7:0] + 8'(k)) ^ 8'h5A;
        chk("read byte", {24'h0, e}, {24'h0, rx[k]});
      end
    end
  endtask
  initial begin
    int m;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'h0;
    rd(8'h05, 32'h0, 1'h0, 1'h0, 1'h1);
    for (m = 0; m < 2; m++) begin
      foreach (ctl[j]) begin
        run(ctl[j], 32'h0, 0, m[0], 1'h0);
        chk("strobe", 32'h1 << j, {28'h0, stb_seen});
        chk("no drive", 32'hFFFFFFFF, lat);
      end
      run(8'hAB, 32'h0, 0, m[0], 1'h0);
      chk("invalid active", 32'h0, {31'h0, act_seen});
      chk("invalid strobe", 32'h0, {28'h0, stb_seen});
      foreach (rdo[j]) begin
        rd(rdo[j], 32'h123456 + j, m[0], j[0], !(m[0] && rdo[j] inside {8'h03, 8'h13}));
      end
    end
    wr_reg_busy = 1'h1;
    rd(8'h0B, 32'h10, 1'h0, 1'h0, 1'h0);
    rd(8'h70, 32'h0, 1'h0, 1'h0, 1'h1);
    wr_reg_busy = 1'h0;
    pe_busy = 1'h1;
    pe_bank = 2'h3;
    rd(8'h0C, 32'h01800020, 1'h0, 1'h0, 1'h0);
    pe_bank = 2'h0;
    rd(8'h0C, 32'h01800020, 1'h0, 1'h0, 1'h1);
    rd(8'hCC, 32'h01800030, 1'h1, 1'h0, 1'h1);
    pe_bank = 2'h2;
    rd(8'h0B, 32'h00000040, 1'h0, 1'h0, 1'h1);
    pe_busy = 1'h0;
    print_verdict;
  end
  // all scenarios need about 20k cycles; give them 50k before calling a hang
  initial begin
    #500000;
    errors++;
    print_verdict;
  end
endmodule // tb_top
